// ===== hw/pess_pkg.sv
// Package of constants for the print engine sensor supervisor
package pess_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  // Default timing figures in milliseconds
  localparam int unsigned TONER_PERIOD_MS = 100;
  localparam int unsigned TONER_SETTLE_MS = 1;
  localparam int unsigned NEAR_LOW_MS = 500;
  localparam int unsigned EMPTY_LOW_MS = 2000;
  localparam int unsigned POS_JAM_MS = 5000;
  localparam int unsigned EXIT_JAM_MS = 5000;
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
  localparam int unsigned TONER_PERIOD_CYC = TONER_PERIOD_MS * MS_CYCLES;
  localparam int unsigned TONER_SETTLE_CYC = TONER_SETTLE_MS * MS_CYCLES;
  localparam int unsigned NEAR_LOW_CYC = NEAR_LOW_MS * MS_CYCLES;
  localparam int unsigned EMPTY_LOW_CYC = EMPTY_LOW_MS * MS_CYCLES;
  localparam int unsigned POS_JAM_CYC = POS_JAM_MS * MS_CYCLES;
  localparam int unsigned EXIT_JAM_CYC = EXIT_JAM_MS * MS_CYCLES;
  // Number of long low periods that must be exceeded
  localparam int unsigned LOW_COUNT_LIMIT = 5;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned OCC_W = 4;
  typedef enum logic [1:0] {
    PESS_TONER_OK = 2'b00,
    PESS_TONER_NEAR = 2'b01,
    PESS_TONER_EMPTY = 2'b10
  } pess_toner_t;
endpackage : pess_pkg

// ===== hw/pess_top.sv
// Print engine sensor supervisor: toner level, fan and recording paper path
`timescale 1ns/1ps
module pess_top #(
  parameter int unsigned TONER_PERIOD = pess_pkg::TONER_PERIOD_CYC,
  parameter int unsigned TONER_SETTLE = pess_pkg::TONER_SETTLE_CYC,
  parameter int unsigned NEAR_LOW = pess_pkg::NEAR_LOW_CYC,
  parameter int unsigned EMPTY_LOW = pess_pkg::EMPTY_LOW_CYC,
  parameter int unsigned POS_JAM = pess_pkg::POS_JAM_CYC,
  // Fuser timeout follows the print-position timeout unless set on its own
  parameter int unsigned EXIT_JAM = POS_JAM
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic toner_level,
  input wire logic fan_lock,
  input wire logic paper_present_n,
  input wire logic print_position_n,
  input wire logic fuser_exit_n,
  input wire logic fan_slow_req,
  input wire logic fan_fast_req,
  input wire logic print_start,
  output logic toner_lamp_on,
  output logic fan_slow_drive,
  output logic fan_fast_drive,
  output logic toner_present,
  output logic toner_near_empty,
  output logic toner_empty,
  output logic fan_locked,
  output logic paper_in_tray,
  output logic paper_at_print,
  output logic paper_in_fuser,
  output logic paper_exited,
  output logic [pess_pkg::CNT_W-1:0] paper_length,
  output logic paper_length_valid,
  output logic jam_print_pos,
  output logic jam_fuser
);
  import pess_pkg::*;

  logic [1:0] rst_sync_reg;
  logic rst_n;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) rst_sync_reg <= 2'b00;
    else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // Two-flop synchronisers; stage 0 read only by stage 1
  localparam int unsigned NIN = 5;
  logic [NIN-1:0] in_raw;
  logic [NIN-1:0] s1_reg;
  logic [NIN-1:0] s2_reg;
  assign in_raw = {fuser_exit_n, print_position_n, paper_present_n, fan_lock, toner_level};
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 5'h1d;
      s2_reg <= 5'h1d;
    end else begin
      s1_reg <= in_raw;
      s2_reg <= s1_reg;
    end
  end
  logic tl_s, fl_s, pe_s, pp_s, fx_s;
  assign {fx_s, pp_s, pe_s, fl_s, tl_s} = s2_reg;

  // Toner measurement cadence
  logic [CNT_W-1:0] per_reg;
  logic per_wrap;
  logic measuring;
  logic sample_ok;
  assign per_wrap = (per_reg == CNT_W'(TONER_PERIOD - 1));
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) per_reg <= '0;
    else if (per_wrap) per_reg <= '0;
    else per_reg <= per_reg + 1'b1;
  end
  // Lamp lit for the whole measuring window; sense sampled after settle
  assign measuring = 1'b1;
  assign sample_ok = measuring && (per_reg >= CNT_W'(TONER_SETTLE));

  logic lamp_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) lamp_reg <= 1'b0;
    else lamp_reg <= measuring;
  end
  assign toner_lamp_on = lamp_reg;

  // Low-period length and occasion counting
  pess_toner_t tstate_reg;
  logic [CNT_W-1:0] low_reg;
  logic [OCC_W-1:0] occ_reg;
  logic toner_low;
  logic low_end;
  logic [CNT_W-1:0] thr;
  logic long_low;
  logic occ_hit;
  assign toner_low = sample_ok && !tl_s;
  assign low_end = lamp_reg && tl_s && (low_reg != '0);
  assign thr = (tstate_reg == PESS_TONER_OK) ? CNT_W'(NEAR_LOW) : CNT_W'(EMPTY_LOW);
  assign long_low = low_end && (low_reg > thr);
  assign occ_hit = long_low && (occ_reg == OCC_W'(LOW_COUNT_LIMIT));
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) low_reg <= '0;
    else if (toner_low && low_reg != '1) low_reg <= low_reg + 1'b1;
    else if (tl_s) low_reg <= '0;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      occ_reg <= '0;
      tstate_reg <= PESS_TONER_OK;
    end else begin
      case (tstate_reg)
        PESS_TONER_OK: begin
          if (occ_hit) begin
            tstate_reg <= PESS_TONER_NEAR;
            occ_reg <= '0;
          end else if (long_low) occ_reg <= occ_reg + 1'b1;
        end
        PESS_TONER_NEAR: begin
          if (occ_hit) begin
            tstate_reg <= PESS_TONER_EMPTY;
            occ_reg <= '0;
          end else if (long_low) occ_reg <= occ_reg + 1'b1;
        end
        PESS_TONER_EMPTY: tstate_reg <= PESS_TONER_EMPTY;
        default: tstate_reg <= PESS_TONER_OK;
      endcase
    end
  end

  // Fan drive and lock; fast wins when both requested
  logic slow_reg, fast_reg, lock_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      slow_reg <= 1'b0;
      fast_reg <= 1'b0;
      lock_reg <= 1'b0;
    end else begin
      slow_reg <= fan_slow_req && !fan_fast_req;
      fast_reg <= fan_fast_req;
      lock_reg <= lock_reg | fl_s;
    end
  end
  assign fan_slow_drive = slow_reg;
  assign fan_fast_drive = fast_reg;
  assign fan_locked = lock_reg;

  // Paper path
  logic tray_reg, at_reg, fuser_reg, exit_reg, fx_d_reg;
  logic printing_reg;
  logic [CNT_W-1:0] len_reg;
  logic [CNT_W-1:0] len_out_reg;
  logic len_v_reg;
  logic [CNT_W-1:0] ex_reg;
  logic jp_reg, jf_reg;
  logic pp_rise;
  logic fx_rise;
  assign pp_rise = printing_reg && pp_s;
  assign fx_rise = fx_s && !fx_d_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tray_reg <= 1'b0;
      at_reg <= 1'b0;
      fuser_reg <= 1'b0;
      fx_d_reg <= 1'b1;
      exit_reg <= 1'b0;
    end else begin
      tray_reg <= !pe_s;
      at_reg <= !pp_s;
      fuser_reg <= !fx_s;
      fx_d_reg <= fx_s;
      exit_reg <= fx_rise;
    end
  end

  // Length saturates rather than wrapping on a stuck sheet
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      printing_reg <= 1'b0;
      len_reg <= '0;
      len_out_reg <= '0;
      len_v_reg <= 1'b0;
    end else begin
      len_v_reg <= 1'b0;
      if (print_start && !pp_s) begin
        printing_reg <= 1'b1;
        len_reg <= '0;
      end else if (pp_rise) begin
        printing_reg <= 1'b0;
        len_out_reg <= len_reg;
        len_v_reg <= 1'b1;
      end else if (printing_reg && len_reg != '1) len_reg <= len_reg + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) ex_reg <= '0;
    else if (fx_s) ex_reg <= '0;
    else if (ex_reg != '1) ex_reg <= ex_reg + 1'b1;
  end

  // Jam flags have no clear; recovery needs a reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      jp_reg <= 1'b0;
      jf_reg <= 1'b0;
    end else begin
      if (printing_reg && !pp_s && len_reg >= CNT_W'(POS_JAM)) jp_reg <= 1'b1;
      if (!fx_s && ex_reg >= CNT_W'(EXIT_JAM)) jf_reg <= 1'b1;
    end
  end

  assign toner_present = tl_s;
  assign toner_near_empty = (tstate_reg != PESS_TONER_OK);
  assign toner_empty = (tstate_reg == PESS_TONER_EMPTY);
  assign paper_in_tray = tray_reg;
  assign paper_at_print = at_reg;
  assign paper_in_fuser = fuser_reg;
  assign paper_exited = exit_reg;
  assign paper_length = len_out_reg;
  assign paper_length_valid = len_v_reg;
  assign jam_print_pos = jp_reg;
  assign jam_fuser = jf_reg;

  // Checks
  // First enabled edge still sees reset values, hence the $past(rst_n) guards
  lamp_lit_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(rst_n) |-> toner_lamp_on) else $error("lamp dark during measurement");
  per_wrap_a: assert property (@(posedge mclk) disable iff (!rst_n)
    per_wrap |=> per_reg == '0) else $error("period not repeating");
  near_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (occ_hit && tstate_reg == PESS_TONER_OK) |=> toner_near_empty && !toner_empty)
    else $error("near empty not entered");
  empty_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (occ_hit && tstate_reg == PESS_TONER_NEAR) |=> toner_empty)
    else $error("empty not entered");
  occ_bound_a: assert property (@(posedge mclk) disable iff (!rst_n)
    occ_reg <= OCC_W'(LOW_COUNT_LIMIT)) else $error("occasion count overrun");
  fan_fast_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fan_fast_req |=> fan_fast_drive && !fan_slow_drive) else $error("fast drive wrong");
  fan_slow_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (fan_slow_req && !fan_fast_req) |=> fan_slow_drive) else $error("slow drive wrong");
  fan_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !fan_slow_req |=> !fan_slow_drive) else $error("slow drive without request");
  lock_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fan_locked |=> fan_locked) else $error("lock flag dropped");
  lock_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
    fl_s |=> fan_locked) else $error("lock not flagged");
  tray_flag_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(rst_n) |-> paper_in_tray == !$past(pe_s)) else $error("tray flag wrong");
  print_pos_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(rst_n) |-> paper_at_print == !$past(pp_s)) else $error("position flag wrong");
  fuser_in_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $past(rst_n) |-> paper_in_fuser == !$past(fx_s)) else $error("fuser flag wrong");
  exit_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (fx_s && !$past(fx_s)) |=> paper_exited ##1 !paper_exited)
    else $error("exit pulse wrong");
  exit_src_a: assert property (@(posedge mclk) disable iff (!rst_n)
    paper_exited |-> $past(fx_s) && !$past(fx_s, 2)) else $error("exit pulse without rise");
  jam_fuse_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (!fx_s && ex_reg >= CNT_W'(EXIT_JAM)) |=> jam_fuser) else $error("fuser jam missed");
  // Only reset clears the sticky flags
  jam_fuse_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    jam_fuser |=> jam_fuser) else $error("fuser jam dropped");
  jam_pos_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (printing_reg && !pp_s && len_reg >= CNT_W'(POS_JAM)) |=> jam_print_pos)
    else $error("print jam missed");
  jam_pos_a: assert property (@(posedge mclk) disable iff (!rst_n)
    jam_print_pos |=> jam_print_pos) else $error("print jam dropped");
  near_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    toner_near_empty |=> toner_near_empty) else $error("near empty dropped");
  empty_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    toner_empty |=> toner_empty) else $error("empty dropped");
  len_out_a: assert property (@(posedge mclk) disable iff (!rst_n)
    pp_rise |=> paper_length_valid && paper_length == $past(len_reg))
    else $error("length not reported");
  len_pulse_a: assert property (@(posedge mclk) disable iff (!rst_n)
    paper_length_valid |=> !paper_length_valid) else $error("length strobe too long");

  near_c: cover property (@(posedge mclk) disable iff (!rst_n) $rose(toner_near_empty));
  empty_c: cover property (@(posedge mclk) disable iff (!rst_n) $rose(toner_empty));
  length_c: cover property (@(posedge mclk) disable iff (!rst_n) paper_length_valid);
  jam_c: cover property (@(posedge mclk) disable iff (!rst_n) $rose(jam_fuser));
  lock_c: cover property (@(posedge mclk) disable iff (!rst_n) $rose(fan_locked));
endmodule : pess_top

// ===== testbench/pess_sensor_model.sv
// Model of the toner sensor, fan rotor sensor and paper path switches
`timescale 1ns/1ps
module pess_sensor_model (
  input wire logic toner_lamp_on,
  input wire logic toner_in,
  input wire logic rotor_stuck,
  input wire logic paper_loaded,
  input wire logic at_print,
  input wire logic in_fuser,
  output logic toner_level,
  output logic fan_lock,
  output logic paper_present_n,
  output logic print_position_n,
  output logic fuser_exit_n
);
  // Unlit cell sees no reflection, so it reads as toner present
  assign toner_level = !(toner_lamp_on && !toner_in);
  assign fan_lock = rotor_stuck;
  assign paper_present_n = !paper_loaded;
  assign print_position_n = !at_print;
  assign fuser_exit_n = !in_fuser;
endmodule : pess_sensor_model

// ===== testbench/tb.sv
// Self-checking bench for the print engine sensor supervisor
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb;
  import pess_pkg::*;
  logic mclk = 0, nrst = 0, toner_in = 1, stuck = 0, loaded = 0, at_print = 0;
  logic in_fuser = 0, slow_req = 0, fast_req = 0, pstart = 0;
  logic toner_level, fan_lock, paper_present_n, print_position_n, fuser_exit_n;
  logic lamp, slow_drv, fast_drv, t_present, t_near, t_empty, locked;
  logic in_tray, at_pos, in_fus, exited, len_valid, jam_pos, jam_fus;
  logic [CNT_W-1:0] len;
  logic [CNT_W-1:0] len_q[$];
  logic [CNT_W-1:0] exp_len;
  int num_errors = 0, checks = 0, exits = 0, t;
  initial forever #12.5 mclk = ~mclk;
  pess_sensor_model model_u (.toner_lamp_on(lamp), .toner_in(toner_in), .rotor_stuck(stuck),
    .paper_loaded(loaded), .at_print(at_print), .in_fuser(in_fuser),
    .toner_level(toner_level), .fan_lock(fan_lock), .paper_present_n(paper_present_n),
    .print_position_n(print_position_n), .fuser_exit_n(fuser_exit_n));
  // Short counts keep the run brief
  pess_top #(.TONER_PERIOD(64), .TONER_SETTLE(2), .NEAR_LOW(10), .EMPTY_LOW(20),
    .POS_JAM(100)) dut_u (.mclk(mclk), .nrst(nrst),
    .toner_level(toner_level), .fan_lock(fan_lock), .paper_present_n(paper_present_n),
    .print_position_n(print_position_n), .fuser_exit_n(fuser_exit_n),
    .fan_slow_req(slow_req), .fan_fast_req(fast_req), .print_start(pstart),
    .toner_lamp_on(lamp), .fan_slow_drive(slow_drv), .fan_fast_drive(fast_drv),
    .toner_present(t_present), .toner_near_empty(t_near), .toner_empty(t_empty),
    .fan_locked(locked), .paper_in_tray(in_tray), .paper_at_print(at_pos),
    .paper_in_fuser(in_fus), .paper_exited(exited), .paper_length(len),
    .paper_length_valid(len_valid), .jam_print_pos(jam_pos), .jam_fuser(jam_fus));
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  task automatic toner_dips(input int n, input int low);
    repeat (n) begin
      toner_in <= 1'b0;
      tick(low);
      toner_in <= 1'b1;
      tick(64 - low);
    end
  endtask : toner_dips
  // Watcher on the negative edge, clear of the design's updates
  always @(negedge mclk) begin
    if (len_valid === 1'b1) begin
      if (len_q.size() > 0) begin
        exp_len = len_q.pop_front();
        `CHK(len, exp_len)
      end else `CHK(len_valid, 1'b0)
    end
    if (exited === 1'b1) exits++;
  end
  initial begin
    tick(20000);
    num_errors++;
    $display("watchdog expired at %0t", $time);
    print_verdict();
  end
  initial begin
    void'($urandom(38));
    tick(2);
    nrst <= 1'b1;
    tick(5);
    `CHK(lamp, 1'b1)
    `CHK(t_present, 1'b1)
    for (int i = 0; i < 4; i++) begin
      slow_req <= i[0];
      fast_req <= i[1];
      tick(2);
      `CHK(slow_drv, i[0] & ~i[1])
      `CHK(fast_drv, i[1])
    end
    stuck <= 1'b1;
    tick(6);
    `CHK(locked, 1'b1)
    stuck <= 1'b0;
    loaded <= 1'b1;
    tick(6);
    `CHK(locked, 1'b1)
    `CHK(in_tray, 1'b1)
    loaded <= 1'b0;
    tick(6);
    `CHK(in_tray, 1'b0)
    $display("test fan and tray done");
    for (int i = 0; i < 2; i++) begin
      t = 20 + ($urandom % 40);
      at_print <= 1'b1;
      tick(5);
      `CHK(at_pos, 1'b1)
      pstart <= 1'b1;
      tick(1);
      pstart <= 1'b0;
      len_q.push_back(CNT_W'(t + 1));
      tick(t - 1);
      at_print <= 1'b0;
      tick(8);
      `CHK(at_pos, 1'b0)
    end
    `CHK(len_q.size(), 0)
    $display("test paper length done");
    at_print <= 1'b1;
    tick(5);
    pstart <= 1'b1;
    tick(1);
    pstart <= 1'b0;
    tick(90);
    `CHK(jam_pos, 1'b0)
    tick(40);
    `CHK(jam_pos, 1'b1)
    // Jammed sheet still reports its length once it clears
    len_q.push_back(CNT_W'(132));
    at_print <= 1'b0;
    in_fuser <= 1'b1;
    tick(30);
    `CHK(jam_pos, 1'b1)
    `CHK(in_fus, 1'b1)
    in_fuser <= 1'b0;
    tick(6);
    `CHK(exits, 1)
    `CHK(in_fus, 1'b0)
    in_fuser <= 1'b1;
    tick(90);
    `CHK(jam_fus, 1'b0)
    tick(40);
    `CHK(jam_fus, 1'b1)
    in_fuser <= 1'b0;
    tick(6);
    `CHK(exits, 2)
    $display("test jams done");
    toner_in <= 1'b0;
    tick(5);
    `CHK(t_present, 1'b0)
    toner_in <= 1'b1;
    tick(70);
    toner_dips(5, 30);
    `CHK(t_near, 1'b0)
    toner_dips(1, 30);
    tick(10);
    `CHK(t_near, 1'b1)
    toner_dips(5, 40);
    `CHK(t_empty, 1'b0)
    toner_dips(1, 40);
    tick(10);
    `CHK(t_empty, 1'b1)
    `CHK(t_near, 1'b1)
    $display("test toner done");
    nrst <= 1'b0;
    tick(2);
    nrst <= 1'b1;
    tick(5);
    `CHK(locked, 1'b0)
    `CHK(t_near, 1'b0)
    `CHK(t_empty, 1'b0)
    `CHK(jam_pos, 1'b0)
    `CHK(jam_fus, 1'b0)
    `CHK(lamp, 1'b1)
    `CHK(len_q.size(), 0)
    $display("test reset done");
    print_verdict();
  end
endmodule : tb
